// file: common/iste_pkg.sv
package iste_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [4:0] OFF_DATA  = 5'h00;
    localparam logic [4:0] OFF_CTRL  = 5'h04;
    localparam logic [4:0] OFF_SAR   = 5'h08;
    localparam logic [4:0] OFF_RAW   = 5'h0C;
    localparam logic [4:0] OFF_MASK  = 5'h10;
    localparam logic [4:0] OFF_MSTAT = 5'h14;
    localparam logic [4:0] OFF_STAT  = 5'h18;
    localparam logic [4:0] OFF_ACLR  = 5'h1C;

    // Event bit positions shared by raw, mask and masked status.
    localparam int EV_RXOVER = 1;
    localparam int EV_RXFULL = 2;
    localparam int EV_RDREQ  = 5;
    localparam int EV_ABORT  = 6;
    localparam int EV_W      = 8;

    // Control, data and status field positions.
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_10BIT  = 3;
    localparam int CTRL_SDIS   = 6;
    localparam int CTRL_W      = 7;
    localparam int CMD_BIT     = 8;
    localparam int SAR_W       = 10;
    localparam int ST_ACT      = 0;
    localparam int ST_TFNF     = 1;
    localparam int ST_TFE      = 2;
    localparam int ST_RECEIVE_FIFO_NOT_EMPTY     = 3;
    localparam int ST_RFF      = 4;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [SAR_W-1:0]  SAR_RST  = 10'h055;
    localparam logic [EV_W-1:0]   MASK_RST = 8'h00;

    // FIFO shape and bit counts.
    localparam int          PW       = 3;
    localparam int          DEPTH    = 8;
    localparam logic [PW:0] FULL_CNT = 4'h8;
    localparam logic [3:0]  BITS     = 4'h8;
    localparam logic [3:0]  LAST_TX  = 4'h7;

    // Link-side states, one-hot.
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_ACKA = 8'h04,
        S_RX   = 8'h08,
        S_ACKR = 8'h10,
        S_STR  = 8'h20,
        S_TX   = 8'h40,
        S_ACKT = 8'h80
    } iste_state_t;

    // Open-drain pin drive group.
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } iste_pins_t;

endpackage

// file: hw/iste_slave.sv
// Design decisions made here: strobed register access and the register offsets.
module iste_slave (
    input  wire logic                clk,    // System clock, 100 MHz.
    input  wire logic                sys_rst, // Synchronous reset.
    input  wire logic [4:0]          addr,   // Register byte address.
    input  wire logic [31:0]         wdata,  // Write data.
    input  wire logic                wr,     // Write strobe.
    input  wire logic                rd,     // Read strobe.
    output logic      [31:0]         rdata,  // Read data, next cycle.
    input  wire logic                scl_i,  // SCL level from pin.
    input  wire logic                sda_i,  // SDA level from pin.
    output iste_pkg::iste_pins_t     pins,   // Pin drives.
    output logic                     irq     // Level interrupt.
);

    function automatic logic hit(input logic s, input logic [4:0] off);
        hit = s && (addr == off);
    endfunction

    // Two-stage synchronisers plus a third stage for edge detection.
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    always_ff @(posedge clk)
    begin
        scl_m_q <= scl_i;
        scl_s_q <= scl_m_q;
        scl_p_q <= scl_s_q;
        sda_m_q <= sda_i;
        sda_s_q <= sda_m_q;
        sda_p_q <= sda_s_q;
    end

    logic rise, fall, start, stop;
    assign rise  = scl_s_q & ~scl_p_q;
    assign fall  = ~scl_s_q & scl_p_q;
    assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // Register and FIFO state.
    logic [iste_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [iste_pkg::SAR_W-1:0]  sar_q, sar_d;
    logic [iste_pkg::EV_W-1:0]   mask_q, mask_d, raw_q, raw_d;
    logic                        hold_q, hold_d, irq_q, irq_d;
    logic [31:0]                 rdata_q, rdata_d;
    logic [7:0]                  txm [iste_pkg::DEPTH];
    logic [7:0]                  rxm [iste_pkg::DEPTH];
    logic [iste_pkg::PW-1:0]     txw_q, txw_d, txr_q, txr_d;
    logic [iste_pkg::PW-1:0]     rxw_q, rxw_d, rxr_q, rxr_d;
    logic [iste_pkg::PW:0]       txc_q, txc_d, rxc_q, rxc_d;
    logic                        tx_we, rx_we;

    // Link state.
    iste_pkg::iste_state_t st_q, st_d;
    iste_pkg::iste_pins_t  pins_q, pins_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic       rw_q, rw_d, nack_q, nack_d, flush_q, flush_d;
    logic       en, rd_ev, ab_ev, push, pop, tx_ok;

    assign en = ~ctrl_q[iste_pkg::CTRL_MASTER] & ~ctrl_q[iste_pkg::CTRL_SDIS];
    assign tx_ok = (txc_q != '0) && !hold_q && !flush_q;

    // Link-side sequencer; it only ever pulls SCL and SDA low.
    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        rw_d    = rw_q;
        nack_d  = nack_q;
        pins_d  = pins_q;
        flush_d = 1'b0;
        rd_ev   = 1'b0;
        ab_ev   = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        if (!en || stop)
        begin
            st_d          = iste_pkg::S_IDLE;
            pins_d.scl_oe = 1'b0;
            pins_d.sda_oe = 1'b0;
        end
        else if (start)
        begin
            st_d          = iste_pkg::S_ADDR;
            cnt_d         = '0;
            pins_d.scl_oe = 1'b0;
            pins_d.sda_oe = 1'b0;
        end
        else
        begin
            case (st_q)
                iste_pkg::S_IDLE:
                begin
                    st_d = iste_pkg::S_IDLE;
                end
                iste_pkg::S_ADDR, iste_pkg::S_RX:
                begin
                    if (rise)
                    begin
                        sh_d  = {sh_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (fall && cnt_q == iste_pkg::BITS)
                    begin
                        if (st_q == iste_pkg::S_RX)
                        begin
                            push          = 1'b1;
                            pins_d.sda_oe = 1'b1;
                            st_d          = iste_pkg::S_ACKR;
                        end
                        else if (sh_q[7:1] == sar_q[6:0])
                        begin
                            pins_d.sda_oe = 1'b1;
                            rw_d          = sh_q[0];
                            st_d          = iste_pkg::S_ACKA;
                        end
                        else
                        begin
                            st_d = iste_pkg::S_IDLE;
                        end
                    end
                end
                iste_pkg::S_ACKR:
                begin
                    if (fall)
                    begin
                        pins_d.sda_oe = 1'b0;
                        cnt_d         = '0;
                        st_d          = iste_pkg::S_RX;
                    end
                end
                iste_pkg::S_ACKA:
                begin
                    if (fall)
                    begin
                        pins_d.sda_oe = 1'b0;
                        cnt_d         = '0;
                        if (rw_q)
                        begin
                            rd_ev         = 1'b1;
                            ab_ev         = (txc_q != '0);
                            flush_d       = (txc_q != '0);
                            pins_d.scl_oe = 1'b1;
                            st_d          = iste_pkg::S_STR;
                        end
                        else
                        begin
                            st_d = iste_pkg::S_RX;
                        end
                    end
                end
                iste_pkg::S_STR:
                begin
                    if (tx_ok)
                    begin
                        pop           = 1'b1;
                        sh_d          = txm[txr_q];
                        pins_d.sda_oe = ~txm[txr_q][7];
                        pins_d.scl_oe = 1'b0;
                        cnt_d         = '0;
                        st_d          = iste_pkg::S_TX;
                    end
                    else
                    begin
                        pins_d.scl_oe = 1'b1;
                    end
                end
                iste_pkg::S_TX:
                begin
                    if (fall)
                    begin
                        if (cnt_q == iste_pkg::LAST_TX)
                        begin
                            pins_d.sda_oe = 1'b0;
                            st_d          = iste_pkg::S_ACKT;
                        end
                        else
                        begin
                            sh_d          = {sh_q[6:0], 1'b0};
                            pins_d.sda_oe = ~sh_q[6];
                            cnt_d         = cnt_q + 4'h1;
                        end
                    end
                end
                iste_pkg::S_ACKT:
                begin
                    if (rise)
                    begin
                        nack_d = sda_s_q;
                    end
                    else if (fall)
                    begin
                        if (nack_q)
                        begin
                            ab_ev   = 1'b1;
                            flush_d = 1'b1;
                            st_d    = iste_pkg::S_IDLE;
                        end
                        else
                        begin
                            // Data ready: one cycle in S_STR, no stretch.
                            rd_ev         = !tx_ok;
                            pins_d.scl_oe = !tx_ok;
                            st_d          = iste_pkg::S_STR;
                        end
                    end
                end
                default:
                begin
                    st_d = iste_pkg::S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q    <= iste_pkg::S_IDLE;
            cnt_q   <= '0;
            sh_q    <= '0;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
            pins_q  <= '0;
            flush_q <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            rw_q    <= rw_d;
            nack_q  <= nack_d;
            pins_q  <= pins_d;
            flush_q <= flush_d;
        end
    end

    // Register side: FIFOs, events and bus answers.
    always_comb
    begin
        ctrl_d  = ctrl_q;
        sar_d   = sar_q;
        mask_d  = mask_q;
        txw_d   = txw_q;
        txr_d   = txr_q;
        txc_d   = txc_q;
        rxw_d   = rxw_q;
        rxr_d   = rxr_q;
        rxc_d   = rxc_q;
        rdata_d = '0;
        tx_we   = 1'b0;
        rx_we   = 1'b0;
        raw_d   = raw_q;
        hold_d  = hold_q;
        if (hit(wr, iste_pkg::OFF_CTRL))
            ctrl_d = wdata[iste_pkg::CTRL_W-1:0];
        if (hit(wr, iste_pkg::OFF_SAR))
            sar_d = wdata[iste_pkg::SAR_W-1:0];
        if (hit(wr, iste_pkg::OFF_MASK))
            mask_d = wdata[iste_pkg::EV_W-1:0];
        if (hit(wr, iste_pkg::OFF_RAW))
            raw_d = raw_d & ~wdata[iste_pkg::EV_W-1:0];
        if (hit(rd, iste_pkg::OFF_ACLR))
        begin
            raw_d[iste_pkg::EV_ABORT] = 1'b0;
            hold_d                    = 1'b0;
        end
        // Transmit FIFO; writes during the flushed hold are dropped.
        if (pop)
        begin
            txr_d = txr_q + 3'h1;
            txc_d = txc_q - 4'h1;
        end
        if (hit(wr, iste_pkg::OFF_DATA) && !wdata[iste_pkg::CMD_BIT]
            && !hold_q && !flush_q && txc_q != iste_pkg::FULL_CNT)
        begin
            tx_we = 1'b1;
            txw_d = txw_q + 3'h1;
            txc_d = txc_d + 4'h1;
        end
        if (flush_q || hold_q)
        begin
            txw_d = '0;
            txr_d = '0;
            txc_d = '0;
        end
        // Receive FIFO; a push onto a full FIFO is lost but flagged.
        if (hit(rd, iste_pkg::OFF_DATA) && rxc_q != '0)
        begin
            rdata_d = {24'h000000, rxm[rxr_q]};
            rxr_d   = rxr_q + 3'h1;
            rxc_d   = rxc_q - 4'h1;
        end
        if (push && rxc_q == iste_pkg::FULL_CNT)
            raw_d[iste_pkg::EV_RXOVER] = 1'b1;
        else if (push)
        begin
            rx_we                      = 1'b1;
            rxw_d                      = rxw_q + 3'h1;
            rxc_d                      = rxc_d + 4'h1;
            raw_d[iste_pkg::EV_RXFULL] = 1'b1;
        end
        // Hardware sets win over software clears in the same cycle.
        if (rd_ev)
            raw_d[iste_pkg::EV_RDREQ] = 1'b1;
        if (ab_ev)
        begin
            raw_d[iste_pkg::EV_ABORT] = 1'b1;
            hold_d                    = 1'b1;
        end
        if (rd)
        begin
            case (addr)
                iste_pkg::OFF_CTRL:  rdata_d = {25'h0, ctrl_q};
                iste_pkg::OFF_SAR:   rdata_d = {22'h0, sar_q};
                iste_pkg::OFF_RAW:   rdata_d = {24'h0, raw_q};
                iste_pkg::OFF_MASK:  rdata_d = {24'h0, mask_q};
                iste_pkg::OFF_MSTAT: rdata_d = {24'h0, raw_q & mask_q};
                iste_pkg::OFF_STAT:
                begin
                    rdata_d[iste_pkg::ST_ACT]  = (st_q != iste_pkg::S_IDLE);
                    rdata_d[iste_pkg::ST_TFNF] = (txc_q != iste_pkg::FULL_CNT);
                    rdata_d[iste_pkg::ST_TFE]  = (txc_q == '0);
                    rdata_d[iste_pkg::ST_RECEIVE_FIFO_NOT_EMPTY] = (rxc_q != '0);
                    rdata_d[iste_pkg::ST_RFF]  = (rxc_q == iste_pkg::FULL_CNT);
                end
                default: rdata_d = rdata_d;
            endcase
        end
        irq_d = |(raw_q & mask_q);
    end

    always_ff @(posedge clk)
    begin
        if (tx_we)
            txm[txw_q] <= wdata[7:0];
        if (rx_we)
            rxm[rxw_q] <= sh_q;
        if (sys_rst)
        begin
            ctrl_q  <= iste_pkg::CTRL_RST;
            sar_q   <= iste_pkg::SAR_RST;
            mask_q  <= iste_pkg::MASK_RST;
            raw_q   <= '0;
            hold_q  <= 1'b0;
            txw_q   <= '0;
            txr_q   <= '0;
            txc_q   <= '0;
            rxw_q   <= '0;
            rxr_q   <= '0;
            rxc_q   <= '0;
            rdata_q <= '0;
            irq_q   <= 1'b0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            sar_q   <= sar_d;
            mask_q  <= mask_d;
            raw_q   <= raw_d;
            hold_q  <= hold_d;
            txw_q   <= txw_d;
            txr_q   <= txr_d;
            txc_q   <= txc_d;
            rxw_q   <= rxw_d;
            rxr_q   <= rxr_d;
            rxc_q   <= rxc_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign pins  = pins_q;
    assign irq   = irq_q;

    // Checks on the behaviour above.
    chk_stretch_hold: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == iste_pkg::S_STR && !tx_ok |=> pins_q.scl_oe)
        else $error("SCL not held while waiting for data.");
    chk_rdreq_raise: assert property (@(posedge clk) disable iff (sys_rst)
        rd_ev |=> raw_q[iste_pkg::EV_RDREQ] && pins_q.scl_oe)
        else $error("Read request not raised with SCL held.");
    chk_abort_flush: assert property (@(posedge clk) disable iff (sys_rst)
        ab_ev |=> flush_q && raw_q[iste_pkg::EV_ABORT] ##1 txc_q == '0)
        else $error("Abort did not flush transmit data.");
    chk_hold_empty: assert property (@(posedge clk) disable iff (sys_rst)
        hold_q && !hit(rd, iste_pkg::OFF_ACLR) |=> hold_q && txc_q == '0)
        else $error("Transmit FIFO left the flushed hold.");
    chk_release_send: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == iste_pkg::S_STR && tx_ok && en && !stop && !start
        |=> !pins_q.scl_oe && st_q == iste_pkg::S_TX)
        else $error("SCL not released once data was ready.");
    chk_rx_overflow: assert property (@(posedge clk) disable iff (sys_rst)
        push && rxc_q == iste_pkg::FULL_CNT && !rd
        |=> raw_q[iste_pkg::EV_RXOVER] && pins_q.sda_oe && $stable(rxc_q))
        else $error("Overflow not flagged or byte not acked.");
    chk_rx_event: assert property (@(posedge clk) disable iff (sys_rst)
        rx_we |=> raw_q[iste_pkg::EV_RXFULL] && rxc_q != '0)
        else $error("Receive event or count missing.");
    chk_nack_abort: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == iste_pkg::S_ACKT && nack_q && fall && en && !stop && !start
        |=> flush_q ##1 raw_q[iste_pkg::EV_ABORT] && hold_q)
        else $error("NACK did not discard transmit data.");
    chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 irq_q == $past(|(raw_q & mask_q)))
        else $error("Interrupt does not follow masked status.");

endmodule

// file: dv/iste_i2c_master.sv
// Remote bus master driving open-drain SCL and SDA; a 1 releases the wire.
module iste_i2c_master (
    input  wire logic scl_line, // Resolved SCL level.
    input  wire logic sda_line, // Resolved SDA level.
    output logic      scl_drv,  // SCL drive, 0 pulls low.
    output logic      sda_drv   // SDA drive, 0 pulls low.
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real Q = 31.25; // Quarter of the 125 ns SCL period.
    int n_rx;

    // Both wires idle released, so the pull-ups hold them high.
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        n_rx = 0;
    end

    // A slave may stretch SCL, so wait for the wire and not the drive.
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_line !== 1'b1 && n < 100000)
        begin
            #10;
            n++;
        end
    endtask

    task automatic i2c_start();
        sda_drv = 1'b1;
        #(Q) scl_drv = 1'b1;
        wait_high();
        #(Q) sda_drv = 1'b0;
        #(Q) scl_drv = 1'b0;
        #(Q);
    endtask

    // Frames end with a STOP, which leaves both wires released.
    task automatic i2c_stop();
        sda_drv = 1'b0;
        #(Q) scl_drv = 1'b1;
        wait_high();
        #(Q) sda_drv = 1'b1;
        #(Q);
    endtask

    task automatic put_bit(input logic b);
        sda_drv = b;
        #(Q) scl_drv = 1'b1;
        wait_high();
        #(2 * Q) scl_drv = 1'b0;
        #(Q);
    endtask

    task automatic get_bit(output logic b);
        sda_drv = 1'b1;
        #(Q) scl_drv = 1'b1;
        wait_high();
        #(Q) b = sda_line;
        #(Q) scl_drv = 1'b0;
        #(Q);
    endtask

    // Bytes go most significant bit first, then the ninth ack bit.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask

    task automatic read_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(~ack);
        n_rx++;
    endtask
endmodule

// file: dv/iste_slave_bench.sv
// Register-level tests with the remote master on the far side of the pins.
module iste_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk;
    logic                 sys_rst;
    logic [4:0]           addr;
    logic [31:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [31:0]          rdata;
    logic                 irq;
    logic                 m_scl;
    logic                 m_sda;
    iste_pkg::iste_pins_t pins;
    wire logic            scl_w;
    wire logic            sda_w;
    int                   n_errors;
    int                   cmp_count;
    logic                 ack;
    logic [31:0]          d;
    logic [7:0]           b0;
    logic [7:0]           b1;
    logic [7:0]           b2;

    // Wired-AND of both parties; the pull-ups win when nobody pulls.
    assign scl_w = m_scl & ~pins.scl_oe;
    assign sda_w = m_sda & ~pins.sda_oe;

    iste_slave DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_i(scl_w),
        .sda_i(sda_w), .pins(pins), .irq(irq));
    iste_i2c_master MST (.scl_line(scl_w), .sda_line(sda_w),
        .scl_drv(m_scl), .sda_drv(m_sda));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic reg_wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] v;
        reg_rd(a, v);
        check(v, exp);
    endtask

    // Events are masked here, so software polls the raw status instead.
    task automatic wait_req(output logic [31:0] v);
        int n;
        n = 0;
        v = '0;
        while (v[iste_pkg::EV_RDREQ] !== 1'b1 && n < 20000)
        begin
            reg_rd(iste_pkg::OFF_RAW, v);
            n++;
        end
    endtask

    task automatic release_tx();
        logic [31:0] v;
        reg_rd(iste_pkg::OFF_ACLR, v);
        reg_wr(iste_pkg::OFF_RAW, 32'h00000060);
    endtask

    // Guards against a hang; the whole run needs well under 100 us.
    initial
    begin
        #500000;
        n_errors++;
        finish_test();
    end

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(iste_pkg::OFF_CTRL, 32'h00000000);
        rd_chk(iste_pkg::OFF_SAR, 32'h00000055);
        rd_chk(iste_pkg::OFF_MASK, 32'h00000000);
        rd_chk(iste_pkg::OFF_RAW, 32'h00000000);
        rd_chk(iste_pkg::OFF_STAT, 32'h00000006);
        rd_chk(5'h02, 32'h00000000);
        reg_wr(iste_pkg::OFF_CTRL, 32'h00000040);
        rd_chk(iste_pkg::OFF_CTRL, 32'h00000040);
        reg_wr(iste_pkg::OFF_SAR, 32'h0000003A);
        // Disabled either way, even the own address gets no acknowledge.
        for (int i = 0; i < 2; i++)
        begin
            MST.i2c_start();
            MST.write_byte(8'h74, ack);
            MST.i2c_stop();
            check({31'h0, ack}, 32'h0);
            reg_wr(iste_pkg::OFF_CTRL, 32'h00000001);
        end
        reg_wr(iste_pkg::OFF_CTRL, 32'h00000000);
        rd_chk(iste_pkg::OFF_SAR, 32'h0000003A);
        // A foreign address must not be acknowledged.
        MST.i2c_start();
        MST.write_byte(8'h22, ack);
        MST.i2c_stop();
        check({31'h0, ack}, 32'h0);
        // Nine bytes into an eight-deep receive FIFO, all acknowledged.
        reg_wr(iste_pkg::OFF_MASK, 32'h00000006);
        MST.i2c_start();
        MST.write_byte(8'h74, ack);
        check({31'h0, ack}, 32'h1);
        for (int i = 0; i < 9; i++)
        begin
            MST.write_byte(8'hC0 + 8'(i), ack);
            check({31'h0, ack}, 32'h1);
        end
        MST.i2c_stop();
        check({31'h0, irq}, 32'h1);
        rd_chk(iste_pkg::OFF_RAW, 32'h00000006);
        rd_chk(iste_pkg::OFF_MSTAT, 32'h00000006);
        reg_rd(iste_pkg::OFF_STAT, d);
        check(d & 32'h00000018, 32'h00000018);
        for (int i = 0; i < 8; i++)
            rd_chk(iste_pkg::OFF_DATA, 32'hC0 + 32'(i));
        rd_chk(iste_pkg::OFF_DATA, 32'h00000000);
        reg_wr(iste_pkg::OFF_RAW, 32'h00000006);
        repeat (2) @(posedge clk);
        #1 check({31'h0, irq}, 32'h0);
        // Stale byte plus a refused command write before the read request.
        reg_wr(iste_pkg::OFF_DATA, 32'h00000099);
        reg_wr(iste_pkg::OFF_DATA, 32'h000001AA);
        fork
            begin
                MST.i2c_start();
                MST.write_byte(8'h75, ack);
                MST.read_byte(1'b1, b0);
                MST.read_byte(1'b1, b1);
                MST.read_byte(1'b0, b2);
                MST.i2c_stop();
            end
            begin
                wait_req(d);
                check(d & 32'h00000060, 32'h00000060);
                check({31'h0, pins.scl_oe}, 32'h1);
                check({30'h0, pins.scl_o, pins.sda_o}, 32'h0);
                reg_rd(iste_pkg::OFF_STAT, d);
                check(d & 32'h00000004, 32'h00000004);
                reg_wr(iste_pkg::OFF_DATA, 32'h0000005B);
                reg_rd(iste_pkg::OFF_STAT, d);
                check(d & 32'h00000004, 32'h00000004);
                release_tx();
                reg_wr(iste_pkg::OFF_DATA, 32'h00000011);
                reg_wr(iste_pkg::OFF_DATA, 32'h00000022);
                wait_req(d);
                check(32'(MST.n_rx), 32'h2);
                check(d & 32'h00000060, 32'h00000020);
                check({31'h0, pins.scl_oe}, 32'h1);
                release_tx();
                reg_wr(iste_pkg::OFF_DATA, 32'h00000033);
                reg_wr(iste_pkg::OFF_DATA, 32'h00000044);
            end
        join
        check({31'h0, ack}, 32'h1);
        check({24'h0, b0}, 32'h00000011);
        check({24'h0, b1}, 32'h00000022);
        check({24'h0, b2}, 32'h00000033);
        reg_rd(iste_pkg::OFF_RAW, d);
        check(d & 32'h00000040, 32'h00000040);
        reg_rd(iste_pkg::OFF_STAT, d);
        check(d & 32'h00000004, 32'h00000004);
        release_tx();
        rd_chk(iste_pkg::OFF_RAW, 32'h00000000);
        finish_test();
    end
endmodule
